// ==== hw/dcc_channel.sv ====
// Purpose: control and status of one dma channel with its wishbone register slave
// Assumes: one clock, synchronous active high reset, inputs synchronous to clk
// Notes: one transfer is in flight at a time: read, then write
//
// Behaviour
// - bus fault bit is ORed read/write fault
// - any bus error halts, always raises interrupt
// - read error sets read fault, write-one clears
// - read pointer within 3 transfers of fault
// - write error sets write fault, write-one clears
// - write pointer within 5 transfers of fault
// - busy rises at start, falls at end
// - clearing enable while busy pauses, busy stays
// - observe bit feeds each transfer to sniffer
// - byte reverse: byte, halfword, word
// - quiet mode: no block-end interrupt, one on null trigger
// - pacing codes 0..0x3a pick request lines
// - codes 0x3b..0x3e pick timers 0..3
// - code 0x3f is permanent request
// - completion fires linked channel unless self
// - wrap select: 0 read, 1 write
// - wrap size n keeps high address bits
// - write step advances write address
// - read step advances read address
// - width codes step 1, 2, 4 bytes
// - preferred flag offered to issue scheduler
// - enable gates triggers and new transfers
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_channel
    import dcc_pkg::*;
#(
    parameter int ADDR_W = 12, // wishbone byte address width
    parameter int NUM_TIMERS = 4, // timers 2 and 3 are optional
    parameter int COUNT_W = 32, // transfer count width
    parameter logic [3:0] CHANNEL_NUM = `DCC_RST_LINK // own channel number
)
(
    input wire logic clk,
    input wire logic rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // pacing sources
    input wire logic [`DCC_NUM_LINES-1:0] dataRequestLine,
    input wire logic [NUM_TIMERS-1:0] timerTick,
    // issue scheduler
    output logic issueRequest,
    output logic issuePreferred,
    input wire logic issueGrant,
    // chaining
    input wire logic chainIn,
    output logic chainFire,
    output logic [3:0] chainTarget,
    // read side of the system bus
    output logic rdReq,
    output logic [31:0] rdAddr,
    output logic [1:0] xferSize,
    input wire logic rdAck,
    input wire logic rdErr,
    input wire logic [31:0] rdData,
    // write side of the system bus
    output logic wrReq,
    output logic [31:0] wrAddr,
    output logic [31:0] wrData,
    input wire logic wrAck,
    input wire logic wrErr,
    // sniffer
    input wire logic sniffActive,
    output logic sniffValid,
    output logic [31:0] sniffData,
    // interrupt flag raise
    output logic irqRaise,
    output logic busy
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (NUM_TIMERS < 2 || NUM_TIMERS > 4)
    begin : bad_timers
        $error("NUM_TIMERS must be 2 to 4");
    end
    if (ADDR_W < 8 || COUNT_W < 1 || COUNT_W > 32)
    begin : bad_widths
        $error("ADDR_W or COUNT_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // functions

    // bytes per transfer for a width code; reserved code treated as word
    function automatic logic [31:0] stepBytes(input logic [1:0] size);
        case (size)
            DCC_SIZE_BYTE: stepBytes = 32'h0000_0001;
            DCC_SIZE_HALF: stepBytes = 32'h0000_0002;
            default: stepBytes = 32'h0000_0004;
        endcase
    endfunction

    // next pointer value with optional ring wrap of the low n bits
    function automatic logic [31:0] advance(input logic [31:0] addr, input logic [1:0] size,
        input logic wrapOn, input logic [3:0] n);
        logic [31:0] sum;
        logic [31:0] keep;
        sum = addr + stepBytes(size);
        keep = (32'h0000_0001 << n) - 32'h0000_0001;
        if (wrapOn && n != 4'h0)
            advance = (addr & ~keep) | (sum & keep);
        else
            advance = sum;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // control fields
    logic enable; // channel on
    logic preferred; // scheduler preference
    logic [1:0] dataSize; // transfer width code
    logic readStep; // read address advances
    logic writeStep; // write address advances
    logic [3:0] wrapSize; // ring size exponent
    logic wrapSel; // 0 wraps reads, 1 wraps writes
    logic [3:0] linkField; // channel fired on completion
    logic [5:0] paceSel; // pacing source select
    logic quiet; // suppress per-block interrupts
    logic byteReverse; // swap data bytes
    logic sniffObserve; // expose data to sniffer
    logic readFault; // sticky read bus error
    logic writeFault; // sticky write bus error

    logic [31:0] readPtr; // current read address
    logic [31:0] writePtr; // current write address
    logic [COUNT_W-1:0] count; // transfers remaining
    dcc_state_t state; // sequencer state
    logic [31:0] swapped; // read data after reversal

    logic [31:0] ctrlView; // control register as read
    logic [31:0] laneMask; // byte lanes of the write
    logic [31:0] ctrlNew; // control after a write merge
    logic busWr; // write strobe, first cycle only
    logic ctrlWr; // write to control register
    logic chainTrigWr; // write to chain trigger register
    logic start; // accepted trigger
    logic paceReq; // selected pacing request
    logic lastDone; // final write of the sequence done
    logic busError; // bus error this cycle

    assign laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign ctrlWr = busWr && wb_adr_i[7:0] == `DCC_OFF_CONTROL;
    assign chainTrigWr = busWr && wb_adr_i[7:0] == `DCC_OFF_CHAIN_TRIG;
    assign ctrlNew = (ctrlView & ~laneMask) | (wb_dat_i & laneMask);
    assign busError = (state == DCC_READ && rdAck && rdErr)
        || (state == DCC_WRITE && wrAck && wrErr);
    assign lastDone = state == DCC_WRITE && wrAck && !wrErr && count == COUNT_W'(1);

    // the upper address bits beyond the map are decoded here so aliases answer zero
    logic inMap;
    assign inMap = (wb_adr_i >> 8) == '0;

    ////////////////////////////////////////////////////////////////////////////////
    // control register view
    always_comb
    begin
        ctrlView = `DCC_RST_WORD;
        ctrlView[`DCC_BIT_BUS_FAULT] = readFault | writeFault;
        ctrlView[`DCC_BIT_READ_FAULT] = readFault;
        ctrlView[`DCC_BIT_WRITE_FAULT] = writeFault;
        ctrlView[28:25] = 4'h0;
        ctrlView[`DCC_BIT_BUSY] = busy;
        ctrlView[`DCC_BIT_SNIFF] = sniffObserve;
        ctrlView[`DCC_BIT_BYTE_REVERSE] = byteReverse;
        ctrlView[`DCC_BIT_QUIET] = quiet;
        ctrlView[`DCC_PACE_HI:`DCC_PACE_LO] = paceSel;
        ctrlView[`DCC_LINK_HI:`DCC_LINK_LO] = linkField;
        ctrlView[`DCC_BIT_WRAP_SEL] = wrapSel;
        ctrlView[`DCC_WRAP_HI:`DCC_WRAP_LO] = wrapSize;
        ctrlView[`DCC_BIT_WRITE_STEP] = writeStep;
        ctrlView[`DCC_BIT_READ_STEP] = readStep;
        ctrlView[`DCC_SIZE_HI:`DCC_SIZE_LO] = dataSize;
        ctrlView[`DCC_BIT_PREFERRED] = preferred;
        ctrlView[`DCC_BIT_ENABLE] = enable;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-write control fields; the status bits in ctrlNew are discarded
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            enable <= 1'b0;
            preferred <= 1'b0;
            dataSize <= DCC_SIZE_BYTE;
            readStep <= 1'b0;
            writeStep <= 1'b0;
            wrapSize <= `DCC_RST_WRAP;
            wrapSel <= 1'b0;
            linkField <= CHANNEL_NUM;
            paceSel <= `DCC_RST_PACE;
            quiet <= 1'b0;
            byteReverse <= 1'b0;
            sniffObserve <= 1'b0;
        end
        else if (ctrlWr && inMap)
        begin
            enable <= ctrlNew[`DCC_BIT_ENABLE];
            preferred <= ctrlNew[`DCC_BIT_PREFERRED];
            dataSize <= ctrlNew[`DCC_SIZE_HI:`DCC_SIZE_LO];
            readStep <= ctrlNew[`DCC_BIT_READ_STEP];
            writeStep <= ctrlNew[`DCC_BIT_WRITE_STEP];
            wrapSize <= ctrlNew[`DCC_WRAP_HI:`DCC_WRAP_LO];
            wrapSel <= ctrlNew[`DCC_BIT_WRAP_SEL];
            linkField <= ctrlNew[`DCC_LINK_HI:`DCC_LINK_LO];
            paceSel <= ctrlNew[`DCC_PACE_HI:`DCC_PACE_LO];
            quiet <= ctrlNew[`DCC_BIT_QUIET];
            byteReverse <= ctrlNew[`DCC_BIT_BYTE_REVERSE];
            sniffObserve <= ctrlNew[`DCC_BIT_SNIFF];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sticky fault flags: a new error wins over a clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            readFault <= 1'b0;
            writeFault <= 1'b0;
        end
        else
        begin
            if (state == DCC_READ && rdAck && rdErr)
                readFault <= 1'b1;
            else if (ctrlWr && inMap && wb_dat_i[`DCC_BIT_READ_FAULT]
                && laneMask[`DCC_BIT_READ_FAULT])
                readFault <= 1'b0;
            if (state == DCC_WRITE && wrAck && wrErr)
                writeFault <= 1'b1;
            else if (ctrlWr && inMap && wb_dat_i[`DCC_BIT_WRITE_FAULT]
                && laneMask[`DCC_BIT_WRITE_FAULT])
                writeFault <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pacing request selection
    always_comb
    begin
        paceReq = 1'b0;
        if (paceSel <= `DCC_PACE_LAST_LINE)
            paceReq = dataRequestLine[paceSel];
        else if (paceSel == `DCC_PACE_ALWAYS)
            paceReq = 1'b1;
        else if (paceSel >= `DCC_PACE_TIMER0 && paceSel <= `DCC_PACE_TIMER3)
        begin
            for (int i = 0; i < NUM_TIMERS; i++)
            begin
                if (paceSel == `DCC_PACE_TIMER0 + 6'(i))
                    paceReq = timerTick[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // trigger acceptance: control write, nonzero chain trigger write or chain input
    // triggers only while enabled
    assign start = state == DCC_IDLE && (count != '0 || (chainTrigWr && wb_dat_i != '0))
        && (ctrlWr && inMap ? ctrlNew[`DCC_BIT_ENABLE] : enable)
        && ((ctrlWr && inMap) || (chainTrigWr && inMap && wb_dat_i != 32'h0000_0000) || chainIn);

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk)
    begin
        if (rst)
            state <= DCC_IDLE;
        else
        begin
            case (state)
                DCC_IDLE: if (start) state <= DCC_WAIT_PACE;
                // paused here while disabled, busy held
                DCC_WAIT_PACE: if (enable && paceReq && issueGrant) state <= DCC_READ;
                DCC_READ:
                    if (rdAck)
                        state <= rdErr ? DCC_IDLE : DCC_WRITE;
                DCC_WRITE:
                    if (wrAck)
                    begin
                        if (wrErr || count == COUNT_W'(1))
                            state <= DCC_IDLE;
                        else
                            state <= DCC_WAIT_PACE;
                    end
                default: state <= DCC_IDLE;
            endcase
        end
    end

    assign busy = state != DCC_IDLE;
    assign issueRequest = state == DCC_WAIT_PACE && enable && paceReq;
    assign issuePreferred = preferred;
    assign rdReq = state == DCC_READ;
    assign wrReq = state == DCC_WRITE;
    assign rdAddr = readPtr;
    assign wrAddr = writePtr;
    assign xferSize = dataSize;

    ////////////////////////////////////////////////////////////////////////////////
    // pointers and count; advance wins over a bus write in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            readPtr <= `DCC_RST_WORD;
            writePtr <= `DCC_RST_WORD;
            count <= '0;
        end
        else
        begin
            // faulting read leaves pointer at its address
            if (state == DCC_READ && rdAck && !rdErr)
            begin
                if (readStep)
                    readPtr <= advance(readPtr, dataSize, !wrapSel, wrapSize);
            end
            else if (busWr && inMap && wb_adr_i[7:0] == `DCC_OFF_READ_PTR)
                readPtr <= (readPtr & ~laneMask) | (wb_dat_i & laneMask);
            // faulting write leaves pointer at its address
            if (state == DCC_WRITE && wrAck && !wrErr)
            begin
                count <= count - COUNT_W'(1);
                if (writeStep)
                    writePtr <= advance(writePtr, dataSize, wrapSel, wrapSize);
            end
            else
            begin
                if (busWr && inMap && wb_adr_i[7:0] == `DCC_OFF_WRITE_PTR)
                    writePtr <= (writePtr & ~laneMask) | (wb_dat_i & laneMask);
                if (busWr && inMap && !busy && wb_adr_i[7:0] == `DCC_OFF_COUNT)
                    count <= COUNT_W'(wb_dat_i);
                else if (chainTrigWr && inMap && !busy)
                    count <= COUNT_W'(wb_dat_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data path: reversal applied on the way from read to write
    // byte reversal
    dcc_byte_reverse u_reverse
    (
        .dataIn(rdData),
        .size(dataSize),
        .enable(byteReverse),
        .dataOut(swapped)
    );

    always_ff @(posedge clk)
    begin
        if (rst)
            wrData <= `DCC_RST_WORD;
        else if (state == DCC_READ && rdAck && !rdErr)
            wrData <= swapped;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sniffer feed: one pulse per completed write while observed
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sniffValid <= 1'b0;
            sniffData <= `DCC_RST_WORD;
        end
        else
        begin
            sniffValid <= state == DCC_WRITE && wrAck && !wrErr && sniffObserve && sniffActive;
            if (state == DCC_WRITE && wrAck && !wrErr)
                sniffData <= wrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt raise and chain fire pulses
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irqRaise <= 1'b0;
            chainFire <= 1'b0;
            chainTarget <= CHANNEL_NUM;
        end
        else
        begin
            // errors always raise; quiet waits for null trigger
            irqRaise <= busError || (lastDone && !quiet)
                || (quiet && chainTrigWr && inMap && wb_dat_i == 32'h0000_0000);
            chainFire <= lastDone && linkField != CHANNEL_NUM;
            chainTarget <= linkField;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone answer: ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `DCC_RST_WORD;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o <= `DCC_RST_WORD;
            if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && inMap)
            begin
                case (wb_adr_i[7:0])
                    `DCC_OFF_READ_PTR: wb_dat_o <= readPtr;
                    `DCC_OFF_WRITE_PTR: wb_dat_o <= writePtr;
                    `DCC_OFF_COUNT: wb_dat_o <= 32'(count);
                    `DCC_OFF_CONTROL: wb_dat_o <= ctrlView;
                    default: wb_dat_o <= `DCC_RST_WORD;
                endcase
            end
        end
    end

endmodule // dcc_channel

// ==== pkg/dcc_consts.svh ====
// Purpose: offsets, field positions, reset values and pacing codes of the channel
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// register byte offsets on the wishbone slave
`define DCC_OFF_READ_PTR 12'h080
`define DCC_OFF_WRITE_PTR 12'h084
`define DCC_OFF_COUNT 12'h088
`define DCC_OFF_CONTROL 12'h08c
`define DCC_OFF_CHAIN_TRIG 12'h090

// control register field positions
`define DCC_BIT_BUS_FAULT 31
`define DCC_BIT_READ_FAULT 30
`define DCC_BIT_WRITE_FAULT 29
`define DCC_BIT_BUSY 24
`define DCC_BIT_SNIFF 23
`define DCC_BIT_BYTE_REVERSE 22
`define DCC_BIT_QUIET 21
`define DCC_PACE_HI 20
`define DCC_PACE_LO 15
`define DCC_LINK_HI 14
`define DCC_LINK_LO 11
`define DCC_BIT_WRAP_SEL 10
`define DCC_WRAP_HI 9
`define DCC_WRAP_LO 6
`define DCC_BIT_WRITE_STEP 5
`define DCC_BIT_READ_STEP 4
`define DCC_SIZE_HI 3
`define DCC_SIZE_LO 2
`define DCC_BIT_PREFERRED 1
`define DCC_BIT_ENABLE 0

// reset values
`define DCC_RST_LINK 4'h2
`define DCC_RST_PACE 6'h00
`define DCC_RST_WRAP 4'h0
`define DCC_RST_WORD 32'h0000_0000

// pacing select codes
`define DCC_PACE_LAST_LINE 6'h3a
`define DCC_PACE_TIMER0 6'h3b
`define DCC_PACE_TIMER3 6'h3e
`define DCC_PACE_ALWAYS 6'h3f
`define DCC_NUM_LINES 59

`endif

// ==== pkg/dcc_pkg.sv ====
// Purpose: types shared by the channel control files
// Assumes: nothing
// Notes: numbers live in dcc_consts.svh
package dcc_pkg;

    // transfer width codes
    typedef enum logic [1:0]
    {
        DCC_SIZE_BYTE = 2'h0,
        DCC_SIZE_HALF = 2'h1,
        DCC_SIZE_WORD = 2'h2,
        DCC_SIZE_RSVD = 2'h3
    } dcc_size_t;

    // channel sequencer states
    typedef enum logic [1:0]
    {
        DCC_IDLE,
        DCC_WAIT_PACE,
        DCC_READ,
        DCC_WRITE
    } dcc_state_t;

endpackage

// ==== hw/dcc_byte_reverse.sv ====
// Purpose: optional byte reversal of one transfer's data
// Assumes: data is right aligned in the low lanes for byte and halfword
// Notes: purely combinational
`timescale 1ns/1ps

module dcc_byte_reverse
    import dcc_pkg::*;
(
    input wire logic [31:0] dataIn,
    input wire logic [1:0] size,
    input wire logic enable,
    output logic [31:0] dataOut
);

    ////////////////////////////////////////////////////////////////////////////////
    // byte data passes, halfword swaps two bytes, word reverses four
    always_comb
    begin
        dataOut = dataIn;
        if (enable)
        begin
            case (size)
                DCC_SIZE_HALF: dataOut = {dataIn[31:16], dataIn[7:0], dataIn[15:8]};
                DCC_SIZE_WORD: dataOut = {dataIn[7:0], dataIn[15:8], dataIn[23:16],
                    dataIn[31:24]};
                default: dataOut = dataIn;
            endcase
        end
    end

endmodule // dcc_byte_reverse

// ==== tb/dcc_channel_properties.sv ====
// Purpose: port-level temporal checks of the channel
// Assumes: single clock, synchronous active high reset
// Notes: bound into every dcc_channel instance
`timescale 1ns/1ps
`include "dcc_consts.svh"
module dcc_channel_properties #(
    parameter int ADDR_W = 12
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic rdReq,
    input wire logic rdAck,
    input wire logic rdErr,
    input wire logic wrReq,
    input wire logic wrAck,
    input wire logic wrErr,
    input wire logic sniffActive,
    input wire logic sniffValid,
    input wire logic chainFire,
    input wire logic [3:0] chainTarget,
    input wire logic irqRaise,
    input wire logic busy
);
default clocking @(posedge clk);
endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
// fault steps of a transfer and the control register read, named once
sequence rdFault;
    rdReq && rdErr;
endsequence
sequence wrFault;
    wrReq && wrErr;
endsequence
sequence ctrlRead;
    wb_ack_o && !wb_we_i && wb_adr_i == `DCC_OFF_CONTROL;
endsequence
chk_fault_halt: assert property ((rdFault or wrFault) |=> !busy && !rdReq && !wrReq)
    else $error("channel kept running after a bus error");
chk_fault_irq: assert property ((rdFault or wrFault) |=> irqRaise)
    else $error("no interrupt after a bus error");
chk_read_write: assert property (rdReq && rdAck && !rdErr |=> wrReq)
    else $error("good read not followed by its write");
chk_busy_cover: assert property (rdReq || wrReq |-> busy)
    else $error("bus request while not busy");
// busy may only drop on a finished write or an error, never on pause
chk_busy_fall: assert property ($fell(busy) |->
    $past(wrReq && (wrAck || wrErr) || rdReq && rdErr))
    else $error("busy fell without a final transfer");
chk_sniff_cause: assert property (sniffValid |->
    $past(wrReq && wrAck && !wrErr && sniffActive))
    else $error("sniff pulse without an observed write");
chk_chain_cause: assert property (chainFire |-> chainTarget != `DCC_RST_LINK
    && $past(wrReq && wrAck))
    else $error("chain pulse without completion or to self");
chk_fault_sum: assert property (ctrlRead |-> wb_dat_o[31] == (wb_dat_o[30] | wb_dat_o[29])
    && wb_dat_o[28:25] == 4'h0)
    else $error("control read shows bad fault sum or reserved bits");
endmodule // dcc_channel_properties

bind dcc_channel dcc_channel_properties #(.ADDR_W(ADDR_W)) i_props (.*);

// ==== tb/dcc_bus_model.sv ====
// Purpose: system bus slave answering channel reads and writes
// Assumes: bench changes lag and fault inputs only between sequences
// Notes: read data shows an inverted pattern between answers
`timescale 1ns/1ps
module dcc_bus_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic rdReq,
    input wire logic wrReq,
    input wire logic [3:0] lag,
    input wire logic failRd,
    input wire logic failWr,
    output logic rdAck,
    output logic rdErr,
    output logic wrAck,
    output logic wrErr,
    output logic [31:0] rdData
);
logic [3:0] waitCnt; // idle cycles before answering
////////////////////////////////////////////////////////////////////////
// answer after lag cycles; an error comes with the acknowledge
always_ff @(posedge clk)
begin
    rdAck <= 1'b0;
    rdErr <= 1'b0;
    wrAck <= 1'b0;
    wrErr <= 1'b0;
    rdData <= ~rdData;
    if (rst)
        waitCnt <= 4'h0;
    else if ((rdReq || wrReq) && !rdAck && !wrAck && !rdErr && !wrErr)
    begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == lag)
        begin
            waitCnt <= 4'h0;
            rdAck <= rdReq;
            rdErr <= rdReq && failRd;
            wrAck <= wrReq;
            wrErr <= wrReq && failWr;
            rdData <= 32'h1122_3344;
        end
    end
end
endmodule // dcc_bus_model

// ==== tb/tb_dcc_channel.sv ====
// Purpose: self-checking bench for the channel control block
// Assumes: bus model answers both sides, grant always given
// Notes: each scenario task judges its own results
`timescale 1ns/1ps
`include "dcc_consts.svh"
module tb_dcc_channel;
logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, issueGrant, chainIn, sniffActive;
logic rdAck, rdErr, wrAck, wrErr, failRd, failWr, wb_ack_o, issueRequest, issuePreferred;
logic chainFire, rdReq, wrReq, sniffValid, irqRaise, busy;
logic [11:0] wb_adr_i;
logic [31:0] wb_dat_i, wb_dat_o, rdData, rdAddr, wrAddr, wrData, sniffData, q;
logic [`DCC_NUM_LINES-1:0] dataRequestLine;
logic [3:0] wb_sel_i, timerTick, chainTarget, lag;
logic [1:0] xferSize;
int fail_count, compares, irqN, chainN, sniffN;
dcc_channel i_dut (.*);
dcc_bus_model i_bus (.*);
////////////////////////////////////////////////////////////////////////
initial
begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
// pulse counters, cleared at the start of each run
always @(posedge clk)
begin
    irqN += irqRaise;
    chainN += chainFire;
    sniffN += sniffValid;
end
task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
        fail_count++;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
endtask
task finish_test;
    if (fail_count == 0 && compares > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask
// classic single cycle; read data lands in q at the ack edge
task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
endtask
task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("busy end", busy, 1'b0);
endtask
task automatic run(input logic [31:0] c, input logic [31:0] n);
    {irqN, chainN, sniffN} = 0;
    wb(1'b1, 12'h080, 32'h0000_0100);
    wb(1'b1, 12'h084, 32'h0000_0200);
    wb(1'b1, 12'h088, n);
    wb(1'b1, 12'h08c, c);
    wait_idle;
endtask
task automatic t_reset;
    wb(1'b0, 12'h08c, 32'h0);
    chk("ctrl reset", q, 32'h0000_1000);
    wb(1'b1, 12'h08c, 32'hffff_fffe);
    wb(1'b0, 12'h08c, 32'h0);
    chk("ctrl reserved", q, 32'h00ff_fffe);
    wb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", q, 32'h0);
endtask
// widths with reversal; slave lag grows with width: 0, 2 and 4 cycles
task automatic t_sizes;
    for (int s = 0; s < 3; s++)
    begin
        lag <= 4'(2 * s);
        sniffActive <= 1'b1;
        run(32'h00df_9031 | (s << 2) | (s == 2 ? 2 : 0), 32'h2);
        chk("rd ptr", rdAddr, 32'h100 + (2 << s));
        chk("wr ptr", wrAddr, 32'h200 + (2 << s));
        chk("width", xferSize, s);
        chk("swap", wrData & 32'((64'h1 << (8 << s)) - 1),
            s == 0 ? 32'h44 : s == 1 ? 32'h4433 : 32'h4433_2211);
        chk("sniffs", sniffN, 2);
        chk("preferred", issuePreferred, s == 2);
        chk("block irq", irqN, 1);
    end
endtask
// eight-byte ring on writes, fixed read address, next_channel_link five
task automatic t_wrap;
    lag <= 4'h0;
    sniffActive <= 1'b0;
    run(32'h009f_ace9, 32'h3);
    chk("wrap wr", wrAddr, 32'h204);
    chk("fixed rd", rdAddr, 32'h100);
    chk("chain", {chainN[3:0], chainTarget}, 8'h15);
    chk("no sniff", sniffN, 0);
endtask
task automatic t_pace(input logic [5:0] code);
    wb(1'b1, 12'h088, 32'h1);
    wb(1'b1, 12'h08c, {code, 15'h1001});
    repeat (8) @(posedge clk);
    chk("unpaced hold", {issueRequest, rdReq, busy}, 3'b001);
    wb(1'b1, 12'h08c, {code, 15'h1000});
    if (code < 6'h3b)
        dataRequestLine[code] <= 1'b1;
    else
        timerTick[code - 6'h3b] <= 1'b1;
    repeat (8) @(posedge clk);
    chk("paused", {issueRequest, rdReq, busy}, 3'b001);
    wb(1'b1, 12'h08c, {code, 15'h1001});
    wait_idle;
    {dataRequestLine, timerTick} <= '0;
endtask
task automatic t_err;
    for (int e = 0; e < 2; e++)
    begin
        {failRd, failWr} <= e ? 2'b01 : 2'b10;
        run(32'h001f_9039, 32'h2);
        {failRd, failWr} <= 2'b00;
        wb(1'b0, 12'h08c, 32'h0);
        chk("fault flags", q[31:29], e ? 3'b101 : 3'b110);
        chk("fault irq", irqN, 1);
        chk("fault ptr", e ? wrAddr <= 32'h214 && wrAddr >= 32'h200
            : rdAddr <= 32'h10c && rdAddr >= 32'h100, 1);
        wb(1'b1, 12'h08c, 32'h6000_0000);
        wb(1'b0, 12'h08c, 32'h0);
        chk("fault clear", q[31:29], 3'b000);
    end
endtask
task automatic t_quiet;
    run(32'h003f_9039, 32'h1);
    chk("quiet block", irqN, 0);
    wb(1'b1, 12'h090, 32'h0);
    repeat (3) @(posedge clk);
    chk("null trigger", irqN, 1);
    wb(1'b1, 12'h090, 32'h1);
    wait_idle;
    chk("trig run", wrAddr, 32'h208);
endtask
initial
begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, issueGrant, chainIn, sniffActive} = 7'b1000100;
    {failRd, failWr, wb_adr_i, wb_dat_i, wb_sel_i, lag} = {2'b00, 12'h0, 32'h0, 4'hf, 4'h0};
    {dataRequestLine, timerTick} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_sizes;
    t_wrap;
    t_pace(6'h05);
    t_pace(6'h3a);
    t_pace(6'h3c);
    t_pace(6'h3e);
    t_err;
    t_quiet;
    finish_test;
end
// hang guard, far beyond the few hundred cycles the scenarios need
initial
begin
    #100000;
    fail_count++;
    finish_test;
end
endmodule // tb_dcc_channel
